// ===== post_div_monitor.sv
`timescale 1ns/1ps
module post_div_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  input wire logic sib_a_clk_i,
  input wire logic third_div_out_o,
  input wire logic fourth_div_out_o
);
  logic [23:0] c3_reg;
  logic [23:0] c4_reg;
  logic [7:0] quiet_reg;
  logic [15:0] h3_reg;
  logic [15:0] h4_reg;
  logic settled;
  logic t3_d;
  logic f4_d;
  // shadow settings; the bench writes full words only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      c3_reg <= synth_post_div_pkg::DIV_RESET;
      c4_reg <= synth_post_div_pkg::DIV_RESET;
      quiet_reg <= 8'h00;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      quiet_reg <= 8'h00;
      if (avs_address_i[9:2] == synth_post_div_pkg::THIRD_DIV_IDX) c3_reg <= avs_writedata_i[23:0];
      if (avs_address_i[9:2] == synth_post_div_pkg::FOURTH_DIV_IDX) c4_reg <= avs_writedata_i[23:0];
    end else if (quiet_reg != 8'hC8) begin
      quiet_reg <= quiet_reg + 8'h01;
    end
  end
  // pin history: shapes are judged 16 cycles late, so a write that lands
  // after an attempt has started can never reach into that attempt
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      h3_reg <= 16'h0000;
      h4_reg <= 16'h0000;
    end else begin
      h3_reg <= {h3_reg[14:0], third_div_out_o};
      h4_reg <= {h4_reg[14:0], fourth_div_out_o};
    end
  end
  assign t3_d = h3_reg[15];
  assign f4_d = h4_reg[15];
  // counters do not restart on writes, so judge only once settled
  assign settled = (quiet_reg == 8'hC8);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence four_hi_s;
    f4_d [*4] ##1 !f4_d;
  endsequence
  sequence third_lf_s;
    t3_d [*6] ##1 !t3_d;
  endsequence
  wait_once_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus wait longer than one cycle");
  plain_div_a: assert property (settled && c3_reg == 24'h000004 && $rose(t3_d)
    |-> t3_d [*2] ##1 !t3_d [*2] ##1 t3_d)
    else $error("plain divide by four shape wrong");
  fourth_lf_a: assert property (settled && c4_reg == 24'hF30002 && $rose(f4_d)
    |-> f4_d [*6] ##1 !f4_d) else $error("fourth lf half period wrong");
  third_lf_a: assert property (settled && c3_reg == 24'hF20002 && $rose(t3_d)
    |-> third_lf_s) else $error("third lf half period wrong");
  pulse_width_a: assert property (settled && c4_reg == 24'hF00003 && $rose(f4_d)
    |-> four_hi_s) else $error("frame pulse width wrong");
  neg_pulse_a: assert property (settled && c4_reg == 24'hF40003 && $fell(f4_d)
    |-> !f4_d [*4] ##1 f4_d) else $error("negative pulse wrong");
  frame_gap_a: assert property (settled && c4_reg == 24'hF00003 && $rose(f4_d)
    |-> ##12 $rose(f4_d)) else $error("frame spacing wrong");
  pulse_edge_a: assert property (settled && c4_reg[23:20] == 4'hF && c4_reg[18:16] == 3'h0
    && $rose(fourth_div_out_o) |-> $past(sib_a_clk_i, 2) != $past(sib_a_clk_i, 3)
    && $past(sib_a_clk_i, 2) == c4_reg[19]) else $error("frame boundary edge wrong");
endmodule : post_div_monitor

bind synth_post_divider_output post_div_monitor u_post_div_monitor (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .sib_a_clk_i(sib_a_clk_i),
  .third_div_out_o(third_div_out_o), .fourth_div_out_o(fourth_div_out_o));

// ===== post_div_regs.sv
`timescale 1ns/1ps
module post_div_regs (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input synth_post_div_pkg::avs_req_t req_i,
  input wire logic [31:0] status_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output synth_post_div_pkg::stage_cfg_t [1:0] cfg_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] readdata;
    logic [1:0][23:0] div;
  } regs_state_t;

  regs_state_t s_reg;
  regs_state_t s_next;

  // byte-lane merge, used for both divider registers
  function automatic logic [23:0] merge_lanes(input logic [23:0] old_v,
                                              input logic [31:0] wdata,
                                              input logic [3:0] be);
    logic [23:0] v;
    v = old_v;
    for (int b = 0; b < 3; b++) begin
      if (be[b]) begin
        v[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return v;
  endfunction : merge_lanes

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, answer on the second
  // ----------------------------------------------------------------
  // waitrequest is combinational so the master sees it in cycle 0
  assign waitrequest_o = (req_i.read | req_i.write) & ~s_reg.ack;

  always_comb begin
    logic [7:0] idx;
    idx = req_i.address[synth_post_div_pkg::ADDR_W-1:2];
    s_next = s_reg;
    s_next.ack = (req_i.read | req_i.write) & ~s_reg.ack;
    // read data is fetched in the wait cycle so it stands at the answer edge
    if (req_i.read && !s_reg.ack) begin
      unique case (idx)
        synth_post_div_pkg::THIRD_DIV_IDX: s_next.readdata = {8'h00, s_reg.div[0]};
        synth_post_div_pkg::FOURTH_DIV_IDX: s_next.readdata = {8'h00, s_reg.div[1]};
        synth_post_div_pkg::STAGE_STATUS_IDX: s_next.readdata = status_i;
        default: s_next.readdata = 32'h00000000; // unmapped reads zero
      endcase
    end
    // write lands only at the edge where waitrequest is low
    if (req_i.write && s_reg.ack) begin
      if (idx == synth_post_div_pkg::THIRD_DIV_IDX) begin
        s_next.div[0] = merge_lanes(s_reg.div[0], req_i.writedata, req_i.byteenable);
      end
      if (idx == synth_post_div_pkg::FOURTH_DIV_IDX) begin
        s_next.div[1] = merge_lanes(s_reg.div[1], req_i.writedata, req_i.byteenable);
      end
    end
  end

  // state register; defaults select plain divide by 64
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg.ack <= 1'b0;
      s_reg.readdata <= 32'h00000000;
      s_reg.div[0] <= synth_post_div_pkg::DIV_RESET;
      s_reg.div[1] <= synth_post_div_pkg::DIV_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata_o = s_reg.readdata;
  assign cfg_o = s_reg.div;

endmodule : post_div_regs

// ===== sib_clock_model.sv
`timescale 1ns/1ps
// ------------------------------
// sibling dividers and lf timebase
// ------------------------------
module sib_clock_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  output logic sib_a_clk_o,
  output logic sib_b_clk_o,
  output logic lf_en_o
);
  logic [1:0] a_reg;
  logic [2:0] b_reg;
  logic [1:0] t_reg;
  // free-running counters: a period 4, b period 6, lf tick every 3
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      a_reg <= 2'h0;
      b_reg <= 3'h0;
      t_reg <= 2'h0;
    end else begin
      a_reg <= a_reg + 2'h1;
      b_reg <= (b_reg == 3'h5) ? 3'h0 : b_reg + 3'h1;
      t_reg <= (t_reg == 2'h2) ? 2'h0 : t_reg + 2'h1;
    end
  end
  assign sib_a_clk_o = a_reg[1];
  assign sib_b_clk_o = (b_reg >= 3'h3);
  assign lf_en_o = (t_reg == 2'h2);
endmodule : sib_clock_model

// ===== synth_post_div_pkg.sv
package synth_post_div_pkg;

  // ----------------------------------------------------------------
  // register map (index * 4 = byte address on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] THIRD_DIV_IDX = 8'h86;
  localparam logic [7:0] FOURTH_DIV_IDX = 8'h89;
  localparam logic [7:0] STAGE_STATUS_IDX = 8'hF0;
  localparam int ADDR_W = 10;
  localparam logic [23:0] DIV_RESET = 24'h000040;

  // ----------------------------------------------------------------
  // field layout and codes
  // ----------------------------------------------------------------
  localparam int KIND_LSB = 20;
  localparam int FRAME_TYPE_BIT = 19;
  localparam int POLARITY_BIT = 18;
  localparam int REF_SEL_LSB = 16;
  localparam logic [3:0] KIND_SPECIAL = 4'hF;
  localparam logic [1:0] THIRD_LF_CODE = 2'h2;
  localparam logic [1:0] FOURTH_LF_CODE = 2'h3;
  localparam logic [1:0] REF_SIB_A = 2'h0;
  localparam logic [1:0] REF_SIB_B = 2'h1;
  localparam logic [1:0] REF_SIB_C = 2'h2;
  localparam logic [1:0] REF_SIB_D = 2'h3;
  localparam int STAGES = 2;

  // one stage setting, packed in register bit order
  typedef struct packed {
    logic [3:0] kind;
    logic frame_type;
    logic polarity;
    logic [1:0] ref_sel;
    logic [15:0] rate;
  } stage_cfg_t;

  typedef enum logic [1:0] {
    MODE_DIV,
    MODE_LF,
    MODE_FRAME
  } stage_mode_t;

  // avalon slave group toward the register file
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

endpackage : synth_post_div_pkg

// ===== synth_post_divider_output.sv
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - selector not all ones: divide by setting
// - third stage code 10: low-frequency clock
// - frame pulse one selected-clock period wide
// - bit 18 sets frame pulse polarity
// - bit 19: boundary mid-pulse or first edge
// - plain mode: frame bits join ratio
// - fourth stage: low bits count frame periods
// - fourth stage code 11: low-frequency clock
// - fourth stage source decode A,B,C,lowfreq
// - even ratios exact duty, odd near half
// - low-frequency near 1Hz, plain from 1KHz
// - third stage source decode A,B,lowfreq,D
// - third stage: low bits count frame periods
module synth_post_divider_output (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sib_a_clk_i,
  input wire logic sib_b_clk_i,
  input wire logic lf_en_i,
  output logic third_div_out_o,
  output logic fourth_div_out_o
);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // per-stage working state
  typedef struct packed {
    logic [23:0] cnt;
    logic clk_out;
    logic sib_prev;
    logic pulse;
    logic pin;
  } stage_state_t;

  typedef struct packed {
    stage_state_t [1:0] st;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  synth_post_div_pkg::stage_cfg_t [1:0] cfg;
  synth_post_div_pkg::avs_req_t bus_req;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // mode from the kind nibble and the stage's own low-frequency code
  function automatic synth_post_div_pkg::stage_mode_t decode_mode(
      input synth_post_div_pkg::stage_cfg_t c, input logic [1:0] lf_code);
    if (c.kind != synth_post_div_pkg::KIND_SPECIAL) begin
      return synth_post_div_pkg::MODE_DIV;
    end else if (c.ref_sel == lf_code) begin
      return synth_post_div_pkg::MODE_LF;
    end else begin
      return synth_post_div_pkg::MODE_FRAME;
    end
  endfunction : decode_mode

  // a ratio of zero would never wrap, so it is taken as one
  function automatic logic [23:0] safe_ratio(input logic [23:0] n);
    return (n == 24'h000000) ? 24'h000001 : n;
  endfunction : safe_ratio

  // next value of a wrapping counter with terminal n-1
  function automatic logic [23:0] wrap_inc(input logic [23:0] c, input logic [23:0] n);
    return (c >= n - 24'h000001) ? 24'h000000 : c + 24'h000001;
  endfunction : wrap_inc

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // group bus pins into the request carrier
  always_comb begin
    bus_req.address = avs_address_i;
    bus_req.read = avs_read_i;
    bus_req.write = avs_write_i;
    bus_req.writedata = avs_writedata_i;
    bus_req.byteenable = avs_byteenable_i;
  end

  // status shows each stage's live output and decoded mode
  assign status_word = {26'h0,
                        decode_mode(cfg[1], synth_post_div_pkg::FOURTH_LF_CODE),
                        decode_mode(cfg[0], synth_post_div_pkg::THIRD_LF_CODE),
                        s_reg.st[1].pin,
                        s_reg.st[0].pin};

  post_div_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .req_i(bus_req),
    .status_i(status_word),
    .readdata_o(avs_readdata_o),
    .waitrequest_o(avs_waitrequest_o),
    .cfg_o(cfg)
  );

  // ----------------------------------------------------------------
  // stage engines
  // ----------------------------------------------------------------
  // one pass per stage; stage 0 is the third divider, stage 1 the fourth
  always_comb begin
    synth_post_div_pkg::stage_mode_t mode;
    synth_post_div_pkg::stage_cfg_t c;
    stage_state_t cur;
    stage_state_t nx;
    logic [1:0] lf_code;
    logic sib;
    logic rise;
    logic fall;
    logic [23:0] full_n;
    logic [23:0] rate_n;
    logic [23:0] half_n;
    logic [23:0] cnt_nx;
    logic at_boundary;
    mode = synth_post_div_pkg::MODE_DIV;
    c = '0;
    cur = '0;
    nx = '0;
    lf_code = 2'h0;
    sib = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    full_n = 24'h000000;
    rate_n = 24'h000000;
    half_n = 24'h000000;
    cnt_nx = 24'h000000;
    at_boundary = 1'b0;
    s_next = s_reg;
    for (int i = 0; i < synth_post_div_pkg::STAGES; i++) begin
      c = cfg[i];
      cur = s_reg.st[i];
      nx = cur;
      lf_code = (i == 0) ? synth_post_div_pkg::THIRD_LF_CODE
                         : synth_post_div_pkg::FOURTH_LF_CODE;
      mode = decode_mode(c, lf_code);

      // source of the frame timing; the low-frequency code is never
      // a source because that code puts the stage in its own lf mode
      if (i == 0) begin
        unique case (c.ref_sel)
          synth_post_div_pkg::REF_SIB_A: sib = sib_a_clk_i;
          synth_post_div_pkg::REF_SIB_B: sib = sib_b_clk_i;
          synth_post_div_pkg::REF_SIB_C: sib = 1'b0;
          synth_post_div_pkg::REF_SIB_D: sib = s_reg.st[1].clk_out;
        endcase
      end else begin
        unique case (c.ref_sel)
          synth_post_div_pkg::REF_SIB_A: sib = sib_a_clk_i;
          synth_post_div_pkg::REF_SIB_B: sib = sib_b_clk_i;
          synth_post_div_pkg::REF_SIB_C: sib = s_reg.st[0].clk_out;
          synth_post_div_pkg::REF_SIB_D: sib = 1'b0;
        endcase
      end
      rise = sib & ~cur.sib_prev;
      fall = ~sib & cur.sib_prev;
      nx.sib_prev = sib;

      // whole 24 bits form the ratio in plain mode, low 16 otherwise
      full_n = safe_ratio(c);
      rate_n = safe_ratio({8'h00, c.rate});

      unique case (mode)
        synth_post_div_pkg::MODE_DIV: begin
          // high for floor(n/2) cycles: even ratios give exactly half,
          // odd ones lose half a cycle, which only matters when n is small
          half_n = {1'b0, full_n[23:1]};
          cnt_nx = wrap_inc(cur.cnt, full_n);
          nx.cnt = cnt_nx;
          nx.clk_out = (full_n == 24'h000001) ? 1'b0 : (cnt_nx < half_n);
          nx.pulse = 1'b0;
          nx.pin = nx.clk_out;
        end
        synth_post_div_pkg::MODE_LF: begin
          // lf_en_i runs at four times the base rate, so a half period
          // of n ticks gives twice base over n; slow rates like 1Hz
          // only need a slow enable and a long ratio
          if (lf_en_i) begin
            nx.cnt = wrap_inc(cur.cnt, rate_n);
            if (cur.cnt >= rate_n - 24'h000001) begin
              nx.clk_out = ~cur.clk_out;
            end
          end
          nx.pulse = 1'b0;
          nx.pin = cur.clk_out;
        end
        synth_post_div_pkg::MODE_FRAME: begin
          // boundary is the rising edge that ends each n-period frame
          at_boundary = (cur.cnt >= rate_n - 24'h000001);
          if (rise) begin
            nx.cnt = wrap_inc(cur.cnt, rate_n);
          end
          if (c.frame_type) begin
            // pulse starts on the boundary edge, one period long
            if (rise) begin
              nx.pulse = at_boundary;
            end
          end else begin
            // pulse runs falling edge to falling edge around the boundary
            if (fall) begin
              nx.pulse = at_boundary;
            end
          end
          nx.clk_out = 1'b0;
          nx.pin = cur.pulse ^ c.polarity;
        end
        default: begin
          nx.cnt = 24'h000000;
          nx.pin = 1'b0;
        end
      endcase
      s_next.st[i] = nx;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // counters restart from zero; the output pin starts low
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // pins come straight from flip-flops to avoid glitches downstream
  assign third_div_out_o = s_reg.st[0].pin;
  assign fourth_div_out_o = s_reg.st[1].pin;

endmodule : synth_post_divider_output

// ===== synth_post_divider_output_tb.sv
`timescale 1ns/1ps
module synth_post_divider_output_tb;
  typedef struct {logic sel; logic [23:0] cfg; logic pol; logic [31:0] width;} row_t;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic wait_req;
  logic sib_a;
  logic sib_b;
  logic lf_en;
  logic third;
  logic fourth;
  logic [31:0] q;
  logic [31:0] w;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  row_t rows [15] = '{
    '{1'b0, 24'h000004, 1'b0, 32'h2},
    '{1'b0, 24'h000007, 1'b0, 32'h3},
    '{1'b1, 24'h000008, 1'b0, 32'h4},
    '{1'b1, 24'hF30002, 1'b0, 32'h6},
    '{1'b0, 24'hF20002, 1'b0, 32'h6},
    '{1'b1, 24'hF00003, 1'b0, 32'h4},
    '{1'b1, 24'hF40003, 1'b1, 32'h4},
    '{1'b1, 24'hF10003, 1'b0, 32'h6},
    '{1'b1, 24'hF80003, 1'b0, 32'h4},
    '{1'b0, 24'h000004, 1'b0, 32'h2},
    '{1'b1, 24'hF20003, 1'b0, 32'h4},
    '{1'b0, 24'hF00003, 1'b0, 32'h4},
    '{1'b0, 24'hF10003, 1'b0, 32'h6},
    '{1'b1, 24'h000008, 1'b0, 32'h4},
    '{1'b0, 24'hF30003, 1'b0, 32'h8}};

  synth_post_divider_output u_synth_post_divider_output (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .sib_a_clk_i(sib_a), .sib_b_clk_i(sib_b), .lf_en_i(lf_en),
    .third_div_out_o(third), .fourth_div_out_o(fourth));
  sib_clock_model u_sib_clock_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sib_a_clk_o(sib_a), .sib_b_clk_o(sib_b), .lf_en_o(lf_en));

  // ------------------------------
  // clock, watchdog and helpers
  // ------------------------------
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // whole run needs about 4000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // hold the request until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= !is_wr;
    wr <= is_wr;
    wdata <= d;
    do @(posedge clk_sys_i); while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  function automatic logic act(input logic sel, input logic pol);
    return (sel ? fourth : third) ^ pol;
  endfunction : act
  // sampled on the falling edge so flop updates have settled
  task automatic measure(input logic sel, input logic pol);
    int n;
    n = 0;
    w = 32'h0;
    @(negedge clk_sys_i);
    while (act(sel, pol) !== 1'b0 && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    while (act(sel, pol) !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    while (act(sel, pol) === 1'b1 && n < 3000) begin
      @(negedge clk_sys_i);
      w++;
      n++;
    end
  endtask : measure

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(1'b0, 10'h218, 32'h0);
    check(q, 32'h00000040);
    bus(1'b0, 10'h224, 32'h0);
    check(q, 32'h00000040);
    measure(1'b0, 1'b0);
    check(w, 32'h20);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].sel ? 10'h224 : 10'h218, {8'h00, rows[i].cfg});
      bus(1'b0, rows[i].sel ? 10'h224 : 10'h218, 32'h0);
      check(q, {8'h00, rows[i].cfg});
      repeat (220) @(posedge clk_sys_i);
      measure(rows[i].sel, rows[i].pol);
      check(w, rows[i].width);
    end
    // frame bits become plain ratio bits when selector is not all ones
    bus(1'b1, 10'h224, 32'h000F0004);
    bus(1'b0, 10'h3C0, 32'h0);
    check({30'h0, q[5:4]}, 32'h0);
    // unmapped place keeps nothing
    bus(1'b1, 10'h004, 32'h00ABCDEF);
    bus(1'b0, 10'h004, 32'h0);
    check(q, 32'h0);
    // second reset in mid-run restores the default
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    bus(1'b0, 10'h224, 32'h0);
    check(q, 32'h00000040);
    measure(1'b1, 1'b0);
    check(w, 32'h20);
    complete_run();
  end
endmodule : synth_post_divider_output_tb
